// >>> design/sarcc_top.v
// successive-approximation conversion control, one clock domain
// assumes comparator and range inputs synchronous to clk_in, host keeps convert_start spacing
// ==========================================
// Overview of operation
// - convert_start rise ends acquisition, begins conversion
// - open sampling switches, then ground arrays
// - sixteen step search, msb first
// - on finish, acquire again, show code, drop busy
// - internal clock times conversion, not serial clock
// - result belongs to the convert_start edge that began it, edges outside acquisition ignored
// - low power state between conversions
// - straight binary sixteen bit output code
// - over range gives ffff, under gives 0000
`include "sarcc_regs.vh"
module sarcc_top #(
    parameter BITS = `SARCC_BITS,
    parameter [3:0] SETTLE_CYCLES = `SARCC_SETTLE_CYCLES,
    parameter [3:0] STEP_CYCLES = `SARCC_STEP_CYCLES
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire convert_start_in,
    input wire comp_high_in,
    input wire over_range_in,
    input wire under_range_in,
    output reg sampling_switch_pos_out,
    output reg sampling_switch_neg_out,
    output reg array_to_input_out,
    output reg [BITS-1:0] array_ref_out,
    output reg [BITS-1:0] code_out,
    output reg done_out,
    output reg busy_out,
    output reg standby_out
);
    // ==========================================
    // states, one-hot
    localparam [4:0] ST_ACQ = 5'h01;
    localparam [4:0] ST_OPEN = 5'h02;
    localparam [4:0] ST_GND = 5'h04;
    localparam [4:0] ST_STEP = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;
    localparam [BITS-1:0] TOP_BIT = {1'b1, {(BITS-1){1'b0}}};
    // ==========================================
    // registers and next values
    reg [4:0] state;
    reg [4:0] next_state;
    reg start_prev;
    reg [3:0] wait_cnt;
    reg [3:0] next_wait_cnt;
    reg [BITS-1:0] bit_mask;
    reg [BITS-1:0] next_bit_mask;
    reg [BITS-1:0] trial;
    reg [BITS-1:0] next_trial;
    reg over_seen;
    reg next_over_seen;
    reg under_seen;
    reg next_under_seen;
    reg next_switch_closed;
    reg next_array_to_input;
    reg [BITS-1:0] next_array_ref;
    reg [BITS-1:0] next_code;
    reg next_done;
    reg next_busy;
    reg next_standby;
    wire start_rise;
    wire last_step;
    wire [BITS-1:0] settled;
    wire [BITS-1:0] advanced;
    // ==========================================
    // decoders
    // wait counter in its last cycle
    function count_last;
        input [3:0] cnt;
        begin
            count_last = (cnt <= 4'h1);
        end
    endfunction
    // saturation of the finished code, over range first
    function [BITS-1:0] clamp_code;
        input over;
        input under;
        input [BITS-1:0] value;
        begin
            if (over) begin
                clamp_code = {BITS{1'b1}};
            end else if (under) begin
                clamp_code = {BITS{1'b0}};
            end else begin
                clamp_code = value;
            end
        end
    endfunction
    // ==========================================
    // per element: decide bit under trial, raise the next one
    genvar g;
    generate
        for (g = 0; g < BITS; g = g + 1) begin : g_element
            assign settled[g] = bit_mask[g] ? comp_high_in : trial[g];
            if (g < BITS - 1) begin : g_lower
                assign advanced[g] = settled[g] | bit_mask[g + 1];
            end else begin : g_top
                assign advanced[g] = settled[g];
            end
        end
    endgenerate
    assign start_rise = convert_start_in & ~start_prev;
    assign last_step = bit_mask[0];
    // ==========================================
    // next state and outputs
    always @* begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_bit_mask = bit_mask;
        next_trial = trial;
        next_over_seen = over_seen;
        next_under_seen = under_seen;
        next_switch_closed = sampling_switch_pos_out;
        next_array_to_input = array_to_input_out;
        next_array_ref = array_ref_out;
        next_code = code_out;
        next_done = 1'b0;
        next_busy = busy_out;
        next_standby = standby_out;
        case (state)
            ST_ACQ: begin
                if (start_rise) begin
                    next_switch_closed = 1'b0;
                    next_standby = 1'b0;
                    next_busy = 1'b1;
                    next_wait_cnt = SETTLE_CYCLES;
                    next_state = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (count_last(wait_cnt)) begin
                    next_array_to_input = 1'b0;
                    next_wait_cnt = SETTLE_CYCLES;
                    next_state = ST_GND;
                end else begin
                    next_wait_cnt = wait_cnt - 4'h1;
                end
            end
            ST_GND: begin
                if (count_last(wait_cnt)) begin
                    next_bit_mask = TOP_BIT;
                    next_trial = TOP_BIT;
                    next_array_ref = TOP_BIT;
                    next_over_seen = over_range_in;
                    next_under_seen = under_range_in;
                    next_wait_cnt = STEP_CYCLES;
                    next_state = ST_STEP;
                end else begin
                    next_wait_cnt = wait_cnt - 4'h1;
                end
            end
            ST_STEP: begin
                if (count_last(wait_cnt)) begin
                    if (last_step) begin
                        next_trial = settled;
                        next_array_ref = settled;
                        next_state = ST_DONE;
                    end else begin
                        next_trial = advanced;
                        next_array_ref = advanced;
                        next_bit_mask = bit_mask >> 1;
                        next_wait_cnt = STEP_CYCLES;
                    end
                end else begin
                    next_wait_cnt = wait_cnt - 4'h1;
                end
            end
            ST_DONE: begin
                next_code = clamp_code(over_seen, under_seen, trial);
                next_done = 1'b1;
                next_busy = 1'b0;
                next_switch_closed = 1'b1;
                next_array_to_input = 1'b1;
                next_array_ref = {BITS{1'b0}};
                next_standby = 1'b1;
                next_state = ST_ACQ;
            end
            default: begin
                next_state = ST_ACQ;
            end
        endcase
    end
    // ==========================================
    // registers, clocked only by clk_in
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= ST_ACQ;
            start_prev <= 1'b0;
            wait_cnt <= 4'h0;
            bit_mask <= {BITS{1'b0}};
            trial <= {BITS{1'b0}};
            over_seen <= 1'b0;
            under_seen <= 1'b0;
            sampling_switch_pos_out <= 1'b1;
            sampling_switch_neg_out <= 1'b1;
            array_to_input_out <= 1'b1;
            array_ref_out <= {BITS{1'b0}};
            code_out <= {BITS{1'b0}};
            done_out <= 1'b0;
            busy_out <= 1'b0;
            standby_out <= 1'b1;
        end else if (clk_en_in) begin
            state <= next_state;
            start_prev <= convert_start_in;
            wait_cnt <= next_wait_cnt;
            bit_mask <= next_bit_mask;
            trial <= next_trial;
            over_seen <= next_over_seen;
            under_seen <= next_under_seen;
            sampling_switch_pos_out <= next_switch_closed;
            sampling_switch_neg_out <= next_switch_closed;
            array_to_input_out <= next_array_to_input;
            array_ref_out <= next_array_ref;
            code_out <= next_code;
            done_out <= next_done;
            busy_out <= next_busy;
            standby_out <= next_standby;
        end
    end
endmodule // sarcc_top

// >>> design/sarcc_regs.vh
// constants for the successive-approximation conversion control block
// assumes inclusion by the single design module under design/
`ifndef SARCC_REGS_VH
`define SARCC_REGS_VH
`define SARCC_BITS 16
`define SARCC_CODE_ZERO 16'h0000
`define SARCC_CODE_FULL 16'hffff
`define SARCC_CODE_MID 16'h8000
`define SARCC_SETTLE_CYCLES 4'h2
`define SARCC_STEP_CYCLES 4'h2
`endif

// >>> test/sarcc_checker_assertions.sv
// ========
// sarcc_checker: port properties of sarcc_top
// assumes default settle and step counts; frozen cycles abort running checks except a_freeze_hold
module sarcc_checker (
    input wire clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire convert_start_in,
    input wire sampling_switch_pos_out,
    input wire sampling_switch_neg_out,
    input wire array_to_input_out,
    input wire [15:0] array_ref_out,
    input wire [15:0] code_out,
    input wire done_out,
    input wire busy_out,
    input wire standby_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in || !clk_en_in);
    sequence s_open; !sampling_switch_pos_out && busy_out; endsequence
    sequence s_ground; array_to_input_out[*2] ##1 !array_to_input_out; endsequence
    a_start_opens: assert property ($rose(convert_start_in) && standby_out |-> ##[1:2] s_open)
        else $error("start edge did not open switches");
    a_ground_after: assert property ($fell(sampling_switch_pos_out) |-> s_ground)
        else $error("arrays not grounded two cycles after switches opened");
    a_msb_first: assert property ($fell(array_to_input_out) |-> ##2 array_ref_out == 16'h8000)
        else $error("search did not start at the top bit");
    a_conv_length: assert property ($rose(busy_out) |-> ##37 (done_out && !busy_out))
        else $error("conversion length wrong");
    a_done_idle: assert property (done_out |-> sampling_switch_pos_out && array_to_input_out
        && standby_out && array_ref_out == 16'h0000) else $error("not back in acquisition");
    a_code_hold: assert property (!done_out |-> $stable(code_out))
        else $error("code changed without done");
    a_standby_level: assert property (standby_out == !busy_out)
        else $error("standby not opposite busy");
    a_switch_pair: assert property (sampling_switch_pos_out == sampling_switch_neg_out)
        else $error("switches differ");
    a_freeze_hold: assert property (disable iff (sys_rst_in) !clk_en_in |=>
        $stable(code_out) && $stable(array_ref_out) && $stable(busy_out))
        else $error("state moved while clock enable low");
endmodule // sarcc_checker

// >>> test/sarcc_analog_model.sv
// ========
// sarcc_analog_model: comparator of a held level against the trial code
// assumes the level stays put for a whole conversion
module sarcc_analog_model (
    input wire [15:0] level_in,
    input wire [15:0] array_ref_in,
    output wire comp_high_out
);
    timeunit 1ns;
    timeprecision 1ps;
    assign comp_high_out = (level_in >= array_ref_in);
endmodule // sarcc_analog_model

// >>> test/tb_sar_conversion_control.sv
// ========
// tb_sar_conversion_control: conversions against the comparator model
// assumes sarcc_top default counts, 38 cycles from start to done plus frozen cycles
module tb_sar_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    // start edge, two settles of 2, sixteen steps of 2, done
    localparam integer CONV_CYCLES = 38;
    logic clk_in = 0, sys_rst_in = 1, clk_en = 1, convert_start_in = 0, over = 0, under = 0;
    logic comp_high, done;
    logic [15:0] level = 0, array_ref, code, r;
    logic [15:0] exp_q[$];
    integer lat_q[$];
    integer errors = 0, cmp_count = 0, cycles = 0, start_cyc = 0, seed = 47, frz = 0, rnd, i, j;
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) cycles <= cycles + 1;
    sarcc_top sarcc_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
        .convert_start_in(convert_start_in), .comp_high_in(comp_high), .over_range_in(over),
        .under_range_in(under), .sampling_switch_pos_out(), .sampling_switch_neg_out(),
        .array_to_input_out(), .array_ref_out(array_ref), .code_out(code), .done_out(done),
        .busy_out(), .standby_out());
    sarcc_analog_model sarcc_analog_model_inst (.level_in(level), .array_ref_in(array_ref),
        .comp_high_out(comp_high));
    task compare_code(input logic [15:0] got, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task compare_cycles(input integer got, input integer exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t cycles got %h expected %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task convert(input logic [15:0] lv, input logic ov, input logic un, input logic [15:0] exp);
        @(negedge clk_in);
        {level, over, under} = {lv, ov, un};
        exp_q.push_back(exp);
        lat_q.push_back(CONV_CYCLES + frz);
        start_cyc = cycles;
        convert_start_in = 1;
        repeat (10) @(negedge clk_in);
        convert_start_in = 0;
        if (frz > 0) begin
            clk_en = 0;
            repeat (frz) @(negedge clk_in);
            clk_en = 1;
        end
        for (i = 0; i < 60 && done !== 1'b1; i++) @(negedge clk_in);
        if (done !== 1'b1) begin
            errors = errors + 1;
            $display("MISMATCH %0t done %h expected %h", $time, done, 1'b1);
        end
        $display("test level %h ov %b un %b freeze %0d done", lv, ov, un, frz);
    endtask
    // ceiling: about sixteen conversions of at most fifty cycles each, with margin
    always @(negedge clk_in) begin
        if (cycles > 2000) begin
            errors = errors + 1;
            complete_run;
        end else if (done === 1'b1) begin
            compare_code(code, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
            compare_cycles(cycles - start_cyc, lat_q.size() ? lat_q.pop_front() : -1);
        end
    end
    initial begin
        repeat (4) @(negedge clk_in);
        sys_rst_in = 0;
        convert(16'h0000, 0, 0, 16'h0000);
        convert(16'h8000, 0, 0, 16'h8000);
        convert(16'h7fff, 0, 0, 16'h7fff);
        convert(16'h0001, 0, 0, 16'h0001);
        convert(16'hffff, 0, 0, 16'hffff);
        for (j = 0; j < 8; j++) begin
            rnd = $random(seed);
            r = rnd[15:0];
            frz = (j % 2) ? 1 + rnd[17:16] : 0;
            convert(r, 0, 0, r);
        end
        frz = 0;
        convert(16'h1234, 1, 0, 16'hffff);
        convert(16'h1234, 0, 1, 16'h0000);
        convert(16'h1234, 1, 1, 16'hffff);
        repeat (2) @(negedge clk_in);
        if (exp_q.size() != 0) begin
            errors = errors + 1;
            $display("MISMATCH %0t pending %h expected %h", $time, exp_q.size(), 0);
        end
        complete_run;
    end
endmodule // tb_sar_conversion_control
bind sarcc_top sarcc_checker sarcc_checker_inst (.*);
